// ### logic/rri_init_if.sv
// carrier from the class decoder to the per-register initializers
// assumes both ends sit on the same core clock
`timescale 1ns/100ps
interface rri_init_if;
   import rri_pkg::*;
   rri_class_e cls;
   rri_bank_t cond;
   modport drv (output cls, output cond);
   modport rcv (input cls, input cond);
endinterface : rri_init_if

// ### logic/rri_pkg.sv
// register reset initialization: constants, class encoding and init tables
// assumes one core clock; table entries are ordered cm2 .. osc, index 0 = osc
package rri_pkg;

   // ******************************************************
   // sizes and indices
   // ******************************************************
   localparam int NUM_REGS = 10;
   localparam int SEL_W = 4;
   localparam int PC_W = 21;
   localparam logic [SEL_W-1:0] SEL_OSC = 4'h0;
   localparam logic [SEL_W-1:0] SEL_WDT = 4'h1;
   localparam logic [SEL_W-1:0] SEL_RESET_CAUSE_CONTROL_REG = 4'h2;
   localparam logic [SEL_W-1:0] SEL_T0 = 4'h3;
   localparam logic [SEL_W-1:0] SEL_T1 = 4'h4;
   localparam logic [SEL_W-1:0] SEL_T2 = 4'h5;
   localparam logic [SEL_W-1:0] SEL_PR2 = 4'h6;
   localparam logic [SEL_W-1:0] SEL_MSK = 4'h7;
   localparam logic [SEL_W-1:0] SEL_CM1 = 4'h8;
   localparam logic [SEL_W-1:0] SEL_CM2 = 4'h9;
   localparam logic [SEL_W-1:0] SEL_FLAGS = 4'ha;
   localparam logic [SEL_W-1:0] SEL_STK = 4'hb;

   // ******************************************************
   // program counter, stack and flags
   // ******************************************************
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
   localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
   localparam logic [7:0] STK_RESET = 8'h00;
   localparam logic [7:0] STK_IMPL = 8'hdf;
   localparam logic [4:0] STK_PTR_MAX = 5'h1f;
   localparam int STK_OVF_BIT = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // ******************************************************
   // reset classes, one-hot
   // ******************************************************
   typedef enum logic [3:0] {
      CLS_IDLE = 4'b0001,
      CLS_POWER = 4'b0010,
      CLS_WARM = 4'b0100,
      CLS_WAKE = 4'b1000
   } rri_class_e;

   typedef logic [NUM_REGS-1:0][7:0] rri_bank_t;

   // ******************************************************
   // init tables: value, condition mask, keep mask, implemented mask
   // ******************************************************
   localparam rri_bank_t VAL_PWR = {8'h1f, 8'h1f, 8'hff, 8'hff, 8'h00,
                                    8'h00, 8'hff, 8'h3c, 8'h80, 8'h64};
   localparam rri_bank_t Q_PWR = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h00, 8'h00, 8'h03, 8'h68, 8'h08};
   localparam rri_bank_t KEEP_PWR = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam rri_bank_t VAL_WARM = {8'h1f, 8'h1f, 8'hff, 8'hff, 8'h00,
                                     8'h00, 8'hff, 8'h00, 8'h80, 8'h64};
   localparam rri_bank_t Q_WARM = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h3c, 8'h60, 8'h08};
   localparam rri_bank_t KEEP_WARM = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'hff, 8'h00, 8'h03, 8'h00, 8'h00};
   localparam rri_bank_t VAL_WAKE = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
   localparam rri_bank_t Q_WAKE = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h3c, 8'h60, 8'h08};
   localparam rri_bank_t KEEP_WAKE = {8'hff, 8'hff, 8'hff, 8'hff, 8'h7f,
                                      8'hff, 8'hff, 8'h83, 8'h8f, 8'hf3};
   localparam rri_bank_t IMPL = {8'hff, 8'hff, 8'hff, 8'hff, 8'h7f,
                                 8'hff, 8'hff, 8'hbf, 8'hef, 8'hff};

endpackage : rri_pkg

// ### logic/rri_reg_init.sv
// next value of one register for the reset class on the carrier
// assumes the caller uses the result only when a class event is present
`timescale 1ns/100ps
module rri_reg_init
   import rri_pkg::*;
#(
   parameter int IDX = 0
)
(
   // class and condition bits
   rri_init_if.rcv init,
   // register value
   input wire logic [7:0] cur_i,
   output logic [7:0] nxt_o
);

   logic [7:0] val;
   logic [7:0] q;
   logic [7:0] keep;

   // ******************************************************
   // table select per class
   // ******************************************************
   always_comb
   begin
      case (init.cls)
         CLS_POWER:
         begin
            val = VAL_PWR[IDX];
            q = Q_PWR[IDX];
            keep = KEEP_PWR[IDX];
         end
         CLS_WARM:
         begin
            val = VAL_WARM[IDX];
            q = Q_WARM[IDX];
            keep = KEEP_WARM[IDX];
         end
         CLS_WAKE:
         begin
            val = VAL_WAKE[IDX];
            q = Q_WAKE[IDX];
            keep = KEEP_WAKE[IDX];
         end
         default:
         begin
            val = 8'h00;
            q = 8'h00;
            keep = 8'hff;
         end
      endcase
   end

   // fixed bits, cause bits, held bits; dead positions forced low
   assign nxt_o = ((val & ~q & ~keep) | (init.cond[IDX] & q) | (cur_i & keep))
                  & IMPL[IDX];

endmodule : rri_reg_init

// ### logic/rri_top.sv
// register reset initialization for the core and peripheral control group
// assumes reset requests and condition bits come from logic on CLK_SYS_I
//
// Overview of operation
// - three reset classes: power-type, warm-type and wake-up select the init set.
// - bits marked held keep their value; unknown bits come out as zero.
// - condition-dependent bits take the cause-supplied value, not a constant.
// - unimplemented bits ignore writes and always read zero.
// - interrupt wake with enables set copies the program counter to stack top.
// - that same wake advances the stack pointer, or sets overflow and holds it when full.
// - that same wake loads the high or low priority vector into the counter.
// - a wake-up sets flag bits recording its cause in the flag register.
// - oscillator control resets to 0110q100; wake forces bit 2 high, bit 3 from cause, holds rest.
// - watchdog control 1qq-q000 on power, 1qq-0000 warm; wake holds top, low.
// - reset cause register 0-1111qq, 0-qqqquu, u-qqqquu; cause bits follow.
// - timer-1 control clears only on power resets, else held.
// - timer-2 control resets to -0000000, held on wake, top bit unimplemented.
// - both comparator controls reset to 00011111, held on wake.
`timescale 1ns/100ps
module rri_top
   import rri_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // reset class requests, one-cycle pulses
   input wire logic PWR_RST_REQ_I,
   input wire logic WARM_RST_REQ_I,
   input wire logic WAKE_REQ_I,
   // wake-up detail
   input wire logic WAKE_BY_IRQ_I,
   input wire logic WAKE_LOW_PRI_I,
   input wire logic [7:0] WAKE_FLAGS_I,
   input wire logic HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I,
   input wire logic LOW_PRIORITY_GLOBAL_IRQ_ENABLE_I,
   // condition bits per cause
   input wire logic [7:0] OSC_COND_I,
   input wire logic [7:0] WDT_COND_I,
   input wire logic [7:0] RESET_CAUSE_CONTROL_REG_COND_I,
   // core side register access
   input wire logic WR_EN_I,
   input wire logic [SEL_W-1:0] WR_SEL_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic [SEL_W-1:0] RD_SEL_I,
   input wire logic [7:0] FLAG_SET_I,
   // program counter from the core
   input wire logic PC_LOAD_I,
   input wire logic [PC_W-1:0] PC_LOAD_VAL_I,
   // state out
   output logic [7:0] RD_DATA_O,
   output logic [PC_W-1:0] PC_O,
   output logic [PC_W-1:0] STACK_TOP_O,
   output logic [7:0] HARDWARE_STACK_POINTER_O,
   output logic [7:0] IRQ_FLAGS_O,
   output logic [3:0] LAST_CLASS_O
);

   // ******************************************************
   // state
   // ******************************************************
   // select map shared by the write and read ports:
   //    0 oscillator control, 1 watchdog control, 2 reset cause control
   //    3 timer-0 control, 4 timer-1 control, 5 timer-2 control
   //    6 timer-2 period, 7 serial address mask
   //    8 comparator one control, 9 comparator two control
   //    a wake flags, b stack pointer
   //    c to f unmapped: writes are dropped and reads return zero
   // the bank follows the table order, so a select is also a table index
   typedef struct packed {
      rri_class_e cls;
      rri_bank_t regs;
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] tos;
      logic [7:0] stk;
      logic [7:0] flags;
      logic [7:0] rd;
   } rri_state_s;

   // reset image: the power-class set with every cause bit at zero, since
   // the condition inputs cannot be trusted while the reset pin is high;
   // the core sees class 0001 until the first request arrives
   localparam rri_state_s STATE_RESET = '{
      cls: CLS_IDLE,
      regs: VAL_PWR & ~Q_PWR & IMPL,
      pc: PC_RESET,
      tos: PC_RESET,
      stk: STK_RESET,
      flags: FLAGS_RESET,
      rd: 8'h00
   };

   rri_state_s s_q;
   rri_state_s s_d;
   rri_class_e cls_now;
   rri_bank_t init_nxt;
   rri_bank_t cond_bank;
   logic irq_vec;
   logic [PC_W-1:0] vec_addr;
   logic [4:0] ptr_next;
   logic wr_bank;
   logic wr_stk;
   logic wr_flags;
   logic rd_bank;
   logic stk_full;
   logic [7:0] flags_idle;
   logic [7:0] rd_next;

   rri_init_if init_if ();

   // ******************************************************
   // class decode
   // ******************************************************
   // limits for the core side:
   //    a write, flag set or counter load in a request cycle is lost, so the
   //    core retries once the request has gone
   //    bits marked unknown come out as zero, not as random values
   //    the condition inputs are read only in the request cycle itself
   //    a wake from the watchdog also forces oscillator bit 2
   // power wins over warm, warm over wake: a deeper reset must never be masked
   always_comb
   begin
      if (PWR_RST_REQ_I)
         cls_now = CLS_POWER;
      else if (WARM_RST_REQ_I)
         cls_now = CLS_WARM;
      else if (WAKE_REQ_I)
         cls_now = CLS_WAKE;
      else
         cls_now = CLS_IDLE;
   end

   // condition bits only matter for the three registers with cause fields
   always_comb
   begin
      cond_bank = '0;
      cond_bank[SEL_OSC] = OSC_COND_I;
      cond_bank[SEL_WDT] = WDT_COND_I;
      cond_bank[SEL_RESET_CAUSE_CONTROL_REG] = RESET_CAUSE_CONTROL_REG_COND_I;
   end

   assign init_if.cls = cls_now;
   assign init_if.cond = cond_bank;

   // ******************************************************
   // per-register initializers
   // ******************************************************
   // one instance per register; tables by index
   generate
      for (genvar i = 0; i < NUM_REGS; i++)
      begin : g_init
         rri_reg_init #(
            .IDX(i)
         ) u_init (
            .init(init_if.rcv),
            .cur_i(s_q.regs[i]),
            .nxt_o(init_nxt[i])
         );
      end
   endgenerate

   // ******************************************************
   // interrupt wake vectoring
   // ******************************************************
   // low priority wake needs both enables, high priority only the high one
   assign irq_vec = WAKE_BY_IRQ_I && HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I
                    && (!WAKE_LOW_PRI_I || LOW_PRIORITY_GLOBAL_IRQ_ENABLE_I);
   assign vec_addr = WAKE_LOW_PRI_I ? VEC_LOW : VEC_HIGH;
   assign ptr_next = 5'(s_q.stk[4:0] + 5'h01);

   // ******************************************************
   // core access decode
   // ******************************************************
   // selects above the table never index the bank
   assign wr_bank = WR_EN_I && (WR_SEL_I < SEL_W'(NUM_REGS));
   assign wr_stk = WR_EN_I && (WR_SEL_I == SEL_STK);
   assign wr_flags = WR_EN_I && (WR_SEL_I == SEL_FLAGS);
   assign rd_bank = RD_SEL_I < SEL_W'(NUM_REGS);
   // write-one-to-clear; a set in the same cycle wins so no cause is lost
   assign flags_idle = wr_flags ? ((s_q.flags & ~WR_DATA_I) | FLAG_SET_I)
                                : (s_q.flags | FLAG_SET_I);
   // pointer at its top: a push must not wrap to zero
   assign stk_full = (s_q.stk[4:0] == STK_PTR_MAX);

   // ******************************************************
   // read port
   // ******************************************************
   // registered one edge behind the select; unmapped selects read zero
   always_comb
   begin
      if (rd_bank)
         rd_next = s_q.regs[RD_SEL_I] & IMPL[RD_SEL_I];
      else if (RD_SEL_I == SEL_FLAGS)
         rd_next = s_q.flags;
      else if (RD_SEL_I == SEL_STK)
         rd_next = s_q.stk & STK_IMPL;
      else
         rd_next = 8'h00;
   end

   // ******************************************************
   // next state
   // ******************************************************
   // per class, in short:
   //    power clears the counter, stack top, stack pointer and flags
   //    warm does the same but keeps the stack error bits
   //    wake ors in the cause flags and either vectors or steps the counter
   //    idle takes core writes, flag sets and counter loads
   // the table update for power, warm and wake comes from the initializers above
   always_comb
   begin
      s_d = s_q;
      case (cls_now)
         CLS_POWER:
         begin
            // deepest class: nothing survives
            s_d.regs = init_nxt;
            s_d.pc = PC_RESET;
            s_d.tos = PC_RESET;
            s_d.stk = STK_RESET;
            s_d.flags = FLAGS_RESET;
         end
         CLS_WARM:
         begin
            // counter and flags restart, tables per warm set
            s_d.regs = init_nxt;
            s_d.pc = PC_RESET;
            s_d.tos = PC_RESET;
            // overflow and underflow flags survive a warm reset
            s_d.stk = {s_q.stk[7:6], 6'h00} & STK_IMPL;
            s_d.flags = FLAGS_RESET;
         end
         CLS_WAKE:
         begin
            // mostly held; only the cause, oscillator bit 2 and the vector or counter step move
            s_d.regs = init_nxt;
            s_d.flags = s_q.flags | WAKE_FLAGS_I;
            if (irq_vec)
            begin
               s_d.tos = s_q.pc;
               // a full stack flags overflow and holds rather than wrapping
               if (stk_full)
                  s_d.stk[STK_OVF_BIT] = 1'b1;
               else
                  s_d.stk[4:0] = ptr_next;
               s_d.pc = vec_addr;
            end
            else
            begin
               s_d.pc = PC_W'(s_q.pc + PC_STEP);
            end
         end
         CLS_IDLE:
         begin
            // register writes, dead positions dropped
            if (wr_bank)
               s_d.regs[WR_SEL_I] = WR_DATA_I & IMPL[WR_SEL_I];
            else if (wr_stk)
               s_d.stk = WR_DATA_I & STK_IMPL;
            s_d.flags = flags_idle;
            if (PC_LOAD_I)
               s_d.pc = PC_LOAD_VAL_I;
         end
         default:
         begin
            s_d = s_q;
         end
      endcase
      if (cls_now != CLS_IDLE)
         s_d.cls = cls_now;
      // read data always follows the select, whatever the class
      s_d.rd = rd_next;
   end

   // ******************************************************
   // state register
   // ******************************************************
   // async reset loads the power-class set with cause bits at zero
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         s_q <= STATE_RESET;
      else
         s_q <= s_d;
   end

   // ******************************************************
   // outputs
   // ******************************************************
   assign RD_DATA_O = s_q.rd;
   assign PC_O = s_q.pc;
   assign STACK_TOP_O = s_q.tos;
   assign HARDWARE_STACK_POINTER_O = s_q.stk;
   assign IRQ_FLAGS_O = s_q.flags;
   assign LAST_CLASS_O = s_q.cls;

endmodule : rri_top

// ### testbench/rri_top_bench.sv
// self-checking bench for the reset initialization top
// assumes the checker is bound in; inputs move on the falling edge
`timescale 1ns/100ps
module rri_top_bench
   import rri_pkg::*;
;
   // ****
   // ports, named as on the block
   // ****
   logic CLK_SYS_I = 1'b0, RST_I = 1'b1, PWR_RST_REQ_I = 1'b0, WARM_RST_REQ_I = 1'b0;
   logic WAKE_REQ_I = 1'b0, WAKE_BY_IRQ_I = 1'b0, WAKE_LOW_PRI_I = 1'b0, WR_EN_I = 1'b0;
   logic HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I = 1'b0, LOW_PRIORITY_GLOBAL_IRQ_ENABLE_I = 1'b0;
   logic [7:0] WAKE_FLAGS_I = '0, OSC_COND_I = '0, WDT_COND_I = '0, RESET_CAUSE_CONTROL_REG_COND_I = '0;
   logic [7:0] WR_DATA_I = '0, FLAG_SET_I = '0, RD_DATA_O, HARDWARE_STACK_POINTER_O, IRQ_FLAGS_O;
   logic [SEL_W-1:0] WR_SEL_I = '0, RD_SEL_I = '0;
   logic [PC_W-1:0] PC_LOAD_VAL_I = '0, PC_O, STACK_TOP_O;
   logic PC_LOAD_I = 1'b0;
   logic [3:0] LAST_CLASS_O;
   int err_total = 0;
   int total_checks = 0;
   // 100 ns core clock
   always #50 CLK_SYS_I = ~CLK_SYS_I;
   rri_top dut (.*);
   // ****
   // helpers
   // ****
   task automatic chk(input string n, input logic [PC_W-1:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   // strobe drops a cycle later, so back-to-back calls never collide
   task automatic wr(input logic [SEL_W-1:0] s, input logic [7:0] d);
      @(negedge CLK_SYS_I);
      WR_EN_I = 1'b1;
      WR_SEL_I = s;
      WR_DATA_I = d;
      @(negedge CLK_SYS_I);
      WR_EN_I = 1'b0;
   endtask : wr
   // one-cycle class pulse, bits are power, warm, wake
   task automatic req(input logic [2:0] r);
      @(negedge CLK_SYS_I);
      {PWR_RST_REQ_I, WARM_RST_REQ_I, WAKE_REQ_I} = r;
      @(negedge CLK_SYS_I);
      {PWR_RST_REQ_I, WARM_RST_REQ_I, WAKE_REQ_I} = 3'h0;
   endtask : req
   // read data is registered one edge behind the select
   task automatic rd(input logic [SEL_W-1:0] s, input logic [7:0] e);
      @(negedge CLK_SYS_I);
      RD_SEL_I = s;
      @(negedge CLK_SYS_I);
      chk($sformatf("reg %0h", s), {13'h0, RD_DATA_O}, {13'h0, e});
   endtask : rd
   task automatic bank(input rri_bank_t e);
      for (int i = 0; i < NUM_REGS; i++)
         rd(i[SEL_W-1:0], e[i]);
   endtask : bank
   // all ones shows which bits a class keeps
   task automatic fill;
      for (int i = 0; i < NUM_REGS; i++)
         wr(i[SEL_W-1:0], 8'hff);
   endtask : fill
   // ****
   // scenarios
   // ****
   task automatic t_rst;
      bank({8'h1f, 8'h1f, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h3c, 8'h80, 8'h64});
      rd(4'hc, 8'h00);
      $display("t_rst done");
   endtask : t_rst
   // every condition bit high shows the q positions
   task automatic t_pwr;
      fill();
      rd(SEL_T2, 8'h7f);
      rd(SEL_WDT, 8'hef);
      rd(SEL_RESET_CAUSE_CONTROL_REG, 8'hbf);
      {OSC_COND_I, WDT_COND_I, RESET_CAUSE_CONTROL_REG_COND_I} = 24'hffffff;
      req(3'h4);
      chk("class", {17'h0, LAST_CLASS_O}, {17'h0, CLS_POWER});
      bank({8'h1f, 8'h1f, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h3f, 8'he8, 8'h6c});
      $display("t_pwr done");
   endtask : t_pwr
   task automatic t_vec;
      @(negedge CLK_SYS_I);
      PC_LOAD_I = 1'b1;
      PC_LOAD_VAL_I = 21'h001234;
      @(negedge CLK_SYS_I);
      PC_LOAD_I = 1'b0;
      {WAKE_BY_IRQ_I, HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I} = 2'h3;
      WAKE_FLAGS_I = 8'h21;
      req(3'h1);
      chk("pc", PC_O, VEC_HIGH);
      chk("tos", STACK_TOP_O, 21'h001234);
      chk("ptr", {13'h0, HARDWARE_STACK_POINTER_O}, 21'h000001);
      chk("flags", {13'h0, IRQ_FLAGS_O & 8'h21}, 21'h000021);
      {WAKE_LOW_PRI_I, LOW_PRIORITY_GLOBAL_IRQ_ENABLE_I} = 2'h3;
      req(3'h1);
      chk("pc", PC_O, VEC_LOW);
      chk("tos", STACK_TOP_O, VEC_HIGH);
      chk("ptr", {13'h0, HARDWARE_STACK_POINTER_O}, 21'h000002);
      // low priority alone is not enough to vector
      HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I = 1'b0;
      req(3'h1);
      chk("pc", PC_O, VEC_LOW + PC_STEP);
      chk("ptr", {13'h0, HARDWARE_STACK_POINTER_O}, 21'h000002);
      $display("t_vec done");
   endtask : t_vec
   task automatic t_warm;
      {WAKE_BY_IRQ_I, WAKE_LOW_PRI_I, LOW_PRIORITY_GLOBAL_IRQ_ENABLE_I} = 3'h0;
      fill();
      {OSC_COND_I, WDT_COND_I, RESET_CAUSE_CONTROL_REG_COND_I} = 24'h000814;
      req(3'h2);
      chk("class", {17'h0, LAST_CLASS_O}, {17'h0, CLS_WARM});
      chk("flags", {13'h0, IRQ_FLAGS_O}, 21'h000000);
      chk("tos", STACK_TOP_O, 21'h000000);
      bank({8'h1f, 8'h1f, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h17, 8'h80, 8'h64});
      $display("t_warm done");
   endtask : t_warm
   task automatic t_wake;
      fill();
      {OSC_COND_I, WDT_COND_I, RESET_CAUSE_CONTROL_REG_COND_I} = 24'h000000;
      req(3'h1);
      chk("class", {17'h0, LAST_CLASS_O}, {17'h0, CLS_WAKE});
      chk("pc", PC_O, PC_STEP);
      bank({8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h83, 8'h8f, 8'hf7});
      $display("t_wake done");
   endtask : t_wake
   // full stack, dropped stack bit, set against clear, class priority, reset
   task automatic t_misc;
      wr(SEL_STK, 8'h3f);
      rd(SEL_STK, 8'h1f);
      {WAKE_BY_IRQ_I, HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I} = 2'h3;
      req(3'h1);
      chk("tos", STACK_TOP_O, PC_STEP);
      chk("ptr", {13'h0, HARDWARE_STACK_POINTER_O}, 21'h00009f);
      req(3'h2);
      chk("pc", PC_O, PC_RESET);
      chk("ptr", {13'h0, HARDWARE_STACK_POINTER_O}, 21'h000080);
      FLAG_SET_I = 8'h01;
      wr(SEL_FLAGS, 8'h01);
      FLAG_SET_I = 8'h00;
      chk("flags", {13'h0, IRQ_FLAGS_O}, 21'h000001);
      wr(SEL_FLAGS, 8'h01);
      rd(SEL_FLAGS, 8'h00);
      req(3'h6);
      chk("class", {17'h0, LAST_CLASS_O}, {17'h0, CLS_POWER});
      @(negedge CLK_SYS_I);
      RST_I = 1'b1;
      @(negedge CLK_SYS_I);
      RST_I = 1'b0;
      chk("class", {17'h0, LAST_CLASS_O}, 21'h000001);
      chk("pc", PC_O, PC_RESET);
      $display("t_misc done");
   endtask : t_misc
   // main sequence
   initial
   begin
      repeat (6) @(posedge CLK_SYS_I);
      @(negedge CLK_SYS_I);
      RST_I = 1'b0;
      t_rst();
      t_pwr();
      t_vec();
      t_warm();
      t_wake();
      t_misc();
      wrap_up();
   end
   // hang guard, far beyond the fewer than two hundred cycles the run needs
   initial
   begin
      #(5000 * 100);
      err_total++;
      wrap_up();
   end
endmodule : rri_top_bench

// ### testbench/rri_top_props.sv
// checker for the reset initialization top, watching its ports only
// assumes one core clock and an active high reset
`timescale 1ns/100ps
module rri_props
   import rri_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // requests
   input wire logic PWR_RST_REQ_I,
   input wire logic WARM_RST_REQ_I,
   input wire logic WAKE_REQ_I,
   input wire logic WAKE_BY_IRQ_I,
   input wire logic WAKE_LOW_PRI_I,
   input wire logic [7:0] WAKE_FLAGS_I,
   input wire logic HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I,
   input wire logic LOW_PRIORITY_GLOBAL_IRQ_ENABLE_I,
   input wire logic [SEL_W-1:0] RD_SEL_I,
   // state
   input wire logic [7:0] RD_DATA_O,
   input wire logic [PC_W-1:0] PC_O,
   input wire logic [PC_W-1:0] STACK_TOP_O,
   input wire logic [7:0] HARDWARE_STACK_POINTER_O,
   input wire logic [7:0] IRQ_FLAGS_O,
   input wire logic [3:0] LAST_CLASS_O
);
   // ****
   // qualifiers
   // ****
   logic wake;
   logic vec;
   logic [1:0] stk_hi;
   logic [4:0] stk_lo;
   // a wake loses to any higher class in the same cycle
   assign wake = WAKE_REQ_I & ~PWR_RST_REQ_I & ~WARM_RST_REQ_I;
   assign vec = wake & WAKE_BY_IRQ_I & HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_I
      & (~WAKE_LOW_PRI_I | LOW_PRIORITY_GLOBAL_IRQ_ENABLE_I);
   assign stk_hi = HARDWARE_STACK_POINTER_O[7:6];
   assign stk_lo = HARDWARE_STACK_POINTER_O[4:0];
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   // ****
   // properties
   // ****
   property p_hi; vec & ~WAKE_LOW_PRI_I |=> PC_O == VEC_HIGH; endproperty
   a_hi: assert property (p_hi) else $error("high vector missed");
   property p_lo; vec & WAKE_LOW_PRI_I |=> PC_O == VEC_LOW; endproperty
   a_lo: assert property (p_lo) else $error("low vector missed");
   property p_tos; vec |=> STACK_TOP_O == $past(PC_O); endproperty
   a_tos: assert property (p_tos) else $error("stack top not loaded");
   property p_ptr; vec && stk_lo != STK_PTR_MAX |=> stk_lo == $past(stk_lo) + 5'h1; endproperty
   a_ptr: assert property (p_ptr) else $error("stack pointer not advanced");
   property p_step; wake & ~vec |=> PC_O == $past(PC_O) + PC_STEP && $stable(STACK_TOP_O); endproperty
   a_step: assert property (p_step) else $error("plain wake counter wrong");
   property p_flag; wake |=> (IRQ_FLAGS_O & $past(WAKE_FLAGS_I)) == $past(WAKE_FLAGS_I); endproperty
   a_flag: assert property (p_flag) else $error("wake flags not set");
   property p_pwr;
      PWR_RST_REQ_I |=> LAST_CLASS_O == CLS_POWER && STACK_TOP_O == '0
         && HARDWARE_STACK_POINTER_O == STK_RESET && IRQ_FLAGS_O == FLAGS_RESET;
   endproperty
   a_pwr: assert property (p_pwr) else $error("power class image wrong");
   property p_warm;
      WARM_RST_REQ_I & ~PWR_RST_REQ_I |=> LAST_CLASS_O == CLS_WARM
         && HARDWARE_STACK_POINTER_O[5:0] == 6'h00 && stk_hi == $past(stk_hi);
   endproperty
   a_warm: assert property (p_warm) else $error("warm class image wrong");
   property p_gap; RD_SEL_I > SEL_STK |=> RD_DATA_O == 8'h00; endproperty
   a_gap: assert property (p_gap) else $error("unmapped read not zero");
   // main scenarios
   c_lo: cover property (vec & WAKE_LOW_PRI_I);
   c_pwr: cover property (PWR_RST_REQ_I);
   c_warm: cover property (WARM_RST_REQ_I & ~PWR_RST_REQ_I);
   c_full: cover property (vec && stk_lo == STK_PTR_MAX);
endmodule : rri_props
bind rri_top rri_props u_props (.*);
